// >>> bbx_alu.sv
// Shared constants and the combinational datapath of the instruction executor.
`timescale 1ns/1ns
package bbx_pkg;
    localparam int INSTR_W = 14;
    localparam int FILE_AW = 7;
    localparam int BIT_FAW = 6;
    localparam int AXI_AW = 5;
    localparam int BYTE_OP_LSB = 8;
    localparam int BIT_OP_LSB = 9;
    localparam int DEST_POS = 7;
    localparam int BIT_IDX_LSB = 6;
    localparam logic [5:0] OP_ADD_FILE = 6'h07;
    localparam logic [5:0] OP_AND_FILE = 6'h05;
    localparam logic [5:0] OP_AND_LIT = 6'h1B;
    localparam logic [4:0] OP_BIT_CLR = 5'h08;
    localparam logic [4:0] OP_BIT_SET = 5'h09;
    localparam logic [4:0] OP_BIT_TEST = 5'h0A;
    localparam logic [AXI_AW-1:0] ADDR_ACC = 5'h00;
    localparam logic [AXI_AW-1:0] ADDR_STATUS = 5'h04;
    localparam logic [AXI_AW-1:0] ADDR_CTRL = 5'h08;
    localparam logic [AXI_AW-1:0] ADDR_COUNT = 5'h0C;
    localparam int ST_CARRY = 0;
    localparam int ST_NIBBLE = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_SKIP = 3;
    localparam int CTRL_EN = 0;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic EN_RST = 1'b1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        ALU_ADD,
        ALU_AND,
        ALU_CLR,
        ALU_SET
    } bbx_alu_op_t;
endpackage

// Arithmetic, logic and single-bit operations on one byte.
module bbx_alu (
    input wire bbx_pkg::bbx_alu_op_t op,
    input wire logic [7:0] acc,
    input wire logic [7:0] opnd,
    input wire logic [2:0] bit_idx,
    output logic [7:0] res,
    output logic carry,
    output logic nibble,
    output logic zero
);
    logic [8:0] sum;
    logic [4:0] low_sum;

    always_comb begin
        sum = {1'b0, acc} + {1'b0, opnd};
        low_sum = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
        res = opnd;
        unique case (op)
            bbx_pkg::ALU_ADD: res = sum[7:0];
            bbx_pkg::ALU_AND: res = acc & opnd;
            bbx_pkg::ALU_CLR: res[bit_idx] = 1'b0;
            bbx_pkg::ALU_SET: res[bit_idx] = 1'b1;
        endcase
        carry = sum[8];
        nibble = low_sum[4];
        zero = (res == 8'h00);
    end
endmodule

// >>> bbx_exec.sv
// Executor for byte add/AND, literal AND and bit clear/set/test-skip.
`timescale 1ns/1ns
module bbx_exec #(
    parameter int CNT_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic instr_valid,
    input wire logic [bbx_pkg::INSTR_W-1:0] instr,
    output logic instr_ready,
    output logic [bbx_pkg::FILE_AW-1:0] file_raddr,
    input wire logic [7:0] file_rdata,
    output logic file_we,
    output logic [bbx_pkg::FILE_AW-1:0] file_waddr,
    output logic [7:0] file_wdata,
    output logic [7:0] acc,
    output logic carry_flag,
    output logic nibble_carry_flag,
    output logic zero_flag,
    output logic skip_pending,
    output logic instr_done,
    output logic instr_discarded,
    output logic instr_unsupported,
    input wire logic [bbx_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [bbx_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // The count is read back through a single 32-bit data word.
    if (CNT_W < 1 || CNT_W > 32) begin : g_cnt_w_check
        $error("CNT_W must lie between 1 and 32.");
    end

    typedef struct packed {
        logic [7:0] acc;
        logic carry;
        logic nibble;
        logic zero;
        logic skip;
        logic enable;
        logic wr_en;
        logic [bbx_pkg::FILE_AW-1:0] wr_addr;
        logic [7:0] wr_data;
        logic done;
        logic discarded;
        logic unsupported;
        logic [CNT_W-1:0] count;
        logic aw_got;
        logic [bbx_pkg::AXI_AW-1:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } bbx_state_t;

    bbx_state_t s_r;
    bbx_state_t s_nxt;

    logic [5:0] byte_op;
    logic [4:0] bit_op;
    logic dest;
    logic [2:0] bit_idx;
    logic [7:0] literal;
    logic is_add;
    logic is_and_file;
    logic is_and_lit;
    logic is_bclr;
    logic is_bset;
    logic is_btest;
    logic [7:0] fdata;
    logic accept;
    bbx_pkg::bbx_alu_op_t alu_op;
    logic [7:0] alu_res;
    logic alu_carry;
    logic alu_nibble;
    logic alu_zero;
    logic [31:0] status_word;

    assign byte_op = instr[bbx_pkg::INSTR_W-1:bbx_pkg::BYTE_OP_LSB];
    assign bit_op = instr[bbx_pkg::INSTR_W-1:bbx_pkg::BIT_OP_LSB];
    assign dest = instr[bbx_pkg::DEST_POS];
    assign bit_idx = instr[bbx_pkg::BIT_OP_LSB-1:bbx_pkg::BIT_IDX_LSB];
    assign literal = instr[7:0];
    assign is_add = (byte_op == bbx_pkg::OP_ADD_FILE);
    assign is_and_file = (byte_op == bbx_pkg::OP_AND_FILE);
    assign is_and_lit = (byte_op == bbx_pkg::OP_AND_LIT);
    assign is_bclr = (bit_op == bbx_pkg::OP_BIT_CLR);
    assign is_bset = (bit_op == bbx_pkg::OP_BIT_SET);
    assign is_btest = (bit_op == bbx_pkg::OP_BIT_TEST);

    // Byte add and file AND address 128 registers, bit operations only 64.
    always_comb begin
        if (is_add || is_and_file) begin
            file_raddr = instr[bbx_pkg::FILE_AW-1:0];
        end else begin
            file_raddr = {1'b0, instr[bbx_pkg::BIT_FAW-1:0]};
        end
    end

    // The write-back leaves a cycle after execution, so a read of the same
    // register in that cycle takes the pending value instead of stale data.
    assign fdata = (s_r.wr_en && s_r.wr_addr == file_raddr) ?
        s_r.wr_data : file_rdata;

    always_comb begin
        if (is_add) begin
            alu_op = bbx_pkg::ALU_ADD;
        end else if (is_bclr) begin
            alu_op = bbx_pkg::ALU_CLR;
        end else if (is_bset) begin
            alu_op = bbx_pkg::ALU_SET;
        end else begin
            alu_op = bbx_pkg::ALU_AND;
        end
    end

    bbx_alu u_alu (
        .op(alu_op),
        .acc(s_r.acc),
        .opnd(is_and_lit ? literal : fdata),
        .bit_idx(bit_idx),
        .res(alu_res),
        .carry(alu_carry),
        .nibble(alu_nibble),
        .zero(alu_zero)
    );

    assign accept = instr_valid && s_r.enable;
    assign status_word = {28'h0000000, s_r.skip, s_r.zero, s_r.nibble,
        s_r.carry};

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.discarded = 1'b0;
        s_nxt.unsupported = 1'b0;
        s_nxt.wr_en = 1'b0;

        // Register bus: write address and data may arrive in either order.
        if (s_axi_awvalid && s_axi_awready) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
        end
        if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = bbx_pkg::RESP_OKAY;
            unique case (s_r.awaddr)
                bbx_pkg::ADDR_ACC: begin
                    if (s_r.wstrb[0]) begin
                        s_nxt.acc = s_r.wdata[7:0];
                    end
                end
                bbx_pkg::ADDR_STATUS: begin
                    if (s_r.wstrb[0]) begin
                        s_nxt.carry = s_r.wdata[bbx_pkg::ST_CARRY];
                        s_nxt.nibble = s_r.wdata[bbx_pkg::ST_NIBBLE];
                        s_nxt.zero = s_r.wdata[bbx_pkg::ST_ZERO];
                    end
                end
                bbx_pkg::ADDR_CTRL: begin
                    if (s_r.wstrb[0]) begin
                        s_nxt.enable = s_r.wdata[bbx_pkg::CTRL_EN];
                    end
                end
                bbx_pkg::ADDR_COUNT: begin
                    s_nxt.bresp = bbx_pkg::RESP_OKAY;
                end
                default: s_nxt.bresp = bbx_pkg::RESP_SLVERR;
            endcase
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = bbx_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                bbx_pkg::ADDR_ACC: s_nxt.rdata = {24'h000000, s_r.acc};
                bbx_pkg::ADDR_STATUS: s_nxt.rdata = status_word;
                bbx_pkg::ADDR_CTRL: s_nxt.rdata = {31'h00000000, s_r.enable};
                bbx_pkg::ADDR_COUNT: s_nxt.rdata = 32'(s_r.count);
                default: begin
                    s_nxt.rdata = 32'h00000000;
                    s_nxt.rresp = bbx_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end

        // Execution comes after the bus so that an instruction result wins
        // over a software write to the same register in the same cycle.
        if (accept) begin
            s_nxt.done = 1'b1;
            s_nxt.count = s_r.count + 1'b1;
            if (s_r.skip) begin
                s_nxt.skip = 1'b0;
                s_nxt.discarded = 1'b1;
            end else if (is_add || is_and_file) begin
                if (dest) begin
                    s_nxt.wr_en = 1'b1;
                    s_nxt.wr_addr = file_raddr;
                    s_nxt.wr_data = alu_res;
                end else begin
                    s_nxt.acc = alu_res;
                end
                s_nxt.zero = alu_zero;
                if (is_add) begin
                    s_nxt.carry = alu_carry;
                    s_nxt.nibble = alu_nibble;
                end
            end else if (is_and_lit) begin
                s_nxt.acc = alu_res;
                s_nxt.zero = alu_zero;
            end else if (is_bclr || is_bset) begin
                s_nxt.wr_en = 1'b1;
                s_nxt.wr_addr = file_raddr;
                s_nxt.wr_data = alu_res;
            end else if (is_btest) begin
                s_nxt.skip = ~fdata[bit_idx];
            end else begin
                s_nxt.unsupported = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.acc <= bbx_pkg::ACC_RST;
            s_r.enable <= bbx_pkg::EN_RST;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // One write and one read at a time keeps the slave free of queues.
    assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
    assign s_axi_wready = !s_r.w_got && !s_r.bvalid;
    assign s_axi_arready = !s_r.rvalid;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;

    assign instr_ready = s_r.enable;
    assign file_we = s_r.wr_en;
    assign file_waddr = s_r.wr_addr;
    assign file_wdata = s_r.wr_data;
    assign acc = s_r.acc;
    assign carry_flag = s_r.carry;
    assign nibble_carry_flag = s_r.nibble;
    assign zero_flag = s_r.zero;
    assign skip_pending = s_r.skip;
    assign instr_done = s_r.done;
    assign instr_discarded = s_r.discarded;
    assign instr_unsupported = s_r.unsupported;
endmodule

// >>> bbx_exec_asserts.sv
// Concurrent checks on the instruction side of the executor.
`timescale 1ns/1ns
module bbx_exec_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic instr_valid,
    input wire logic instr_ready,
    input wire logic [bbx_pkg::INSTR_W-1:0] instr,
    input wire logic [bbx_pkg::FILE_AW-1:0] file_raddr,
    input wire logic [7:0] file_rdata,
    input wire logic file_we,
    input wire logic [bbx_pkg::FILE_AW-1:0] file_waddr,
    input wire logic [7:0] file_wdata,
    input wire logic [7:0] acc,
    input wire logic carry_flag,
    input wire logic nibble_carry_flag,
    input wire logic zero_flag,
    input wire logic skip_pending,
    input wire logic instr_done,
    input wire logic instr_discarded
);
    logic took, take, add_op, and_lit, clr_op, set_op, tst_op;
    logic [7:0] opnd, bmask;
    logic [8:0] sum;
    logic [4:0] nib;
    assign took = ce && instr_valid && instr_ready;
    assign take = took && !skip_pending;
    assign add_op = instr[13:8] == bbx_pkg::OP_ADD_FILE;
    assign and_lit = instr[13:8] == bbx_pkg::OP_AND_LIT;
    assign clr_op = instr[13:9] == bbx_pkg::OP_BIT_CLR;
    assign set_op = instr[13:9] == bbx_pkg::OP_BIT_SET;
    assign tst_op = instr[13:9] == bbx_pkg::OP_BIT_TEST;
    // A pending write is not yet in the file, so its data is the operand.
    assign opnd = (file_we && file_waddr == file_raddr) ? file_wdata
        : file_rdata;
    assign sum = {1'h0, acc} + {1'h0, opnd};
    assign nib = {1'h0, acc[3:0]} + {1'h0, opnd[3:0]};
    assign bmask = 8'h01 << instr[8:6];
    default clocking dcb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    chk_done_pulse: assert property (took |=> instr_done)
        else $error("no done pulse");
    chk_add_acc: assert property (take && add_op && !instr[7]
        |=> {carry_flag, acc} == $past(sum)) else $error("add to acc");
    chk_add_flags: assert property (take && add_op
        |=> nibble_carry_flag == $past(nib[4])
        && zero_flag == ($past(sum[7:0]) == 8'h00)) else $error("add flags");
    chk_add_file: assert property (take && add_op && instr[7]
        |=> file_we && file_waddr == $past(instr[6:0])
        && file_wdata == $past(sum[7:0])) else $error("add to file");
    chk_and_lit: assert property (take && and_lit
        |=> acc == $past(acc & instr[7:0]) && zero_flag == (acc == 8'h00))
        else $error("literal and");
    chk_bit_clr: assert property (take && clr_op
        |=> file_we && file_waddr == {1'h0, $past(instr[5:0])}
        && file_wdata == $past(opnd & ~bmask)) else $error("bit clear");
    chk_bit_set: assert property (take && set_op
        |=> file_we && file_waddr == {1'h0, $past(instr[5:0])}
        && file_wdata == $past(opnd | bmask)) else $error("bit set");
    chk_skip_arm: assert property (take && tst_op
        && !(|(opnd & bmask)) |=> skip_pending && !file_we)
        else $error("skip not armed");
    chk_skip_drop: assert property (took && skip_pending
        |=> instr_discarded && !skip_pending && !file_we)
        else $error("skip not taken");
    cover property (take && tst_op);
    cover property (instr_discarded);
    cover property (take && add_op && instr[7]);
endmodule
bind bbx_exec bbx_exec_chk i_bbx_exec_chk (.*);

// >>> bbx_exec_tb_top.sv
// Self-checking bench for the instruction executor.
`timescale 1ns/1ns
module bbx_exec_tb_top;
    logic aclk, aresetn, ce, instr_valid, instr_ready, file_we;
    logic carry_flag, nibble_carry_flag, zero_flag, skip_pending;
    logic instr_done, instr_discarded, instr_unsupported;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [bbx_pkg::INSTR_W-1:0] instr;
    logic [bbx_pkg::FILE_AW-1:0] file_raddr, file_waddr;
    logic [7:0] file_rdata, file_wdata, acc;
    logic [bbx_pkg::AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] fmem [128];
    int errors, checks_done, cyc, n_instr;
    bbx_exec i_bbx_exec (.*);
    assign file_rdata = fmem[file_raddr];
    always #20 aclk = ~aclk;
    always @(posedge aclk) begin
        if (ce && file_we) fmem[file_waddr] <= file_wdata;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d,
        input logic [1:0] er = bbx_pkg::RESP_OKAY);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        cmp(s_axi_bresp, er);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e,
        input logic [1:0] er = bbx_pkg::RESP_OKAY);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        cmp(s_axi_rdata, e);
        cmp(s_axi_rresp, er);
    endtask
    // Valid stays up between calls so instructions go back to back.
    task automatic ex(input logic [13:0] w);
        @(posedge aclk);
        instr <= w;
        instr_valid <= 1'h1;
        n_instr++;
    endtask
    task automatic idle();
        @(posedge aclk);
        instr_valid <= 1'h0;
        @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic one(input logic [13:0] w);
        ex(w);
        @(posedge aclk);
        instr_valid <= 1'h0;
        @(negedge aclk);
    endtask
    function automatic logic [13:0] fop(logic [5:0] o, logic d, logic [6:0] f);
        return {o, d, f};
    endfunction
    function automatic logic [13:0] bop(logic [4:0] o, logic [2:0] b,
        logic [5:0] f);
        return {o, b, f};
    endfunction
    task automatic t_bus();
        rd(bbx_pkg::ADDR_CTRL, 32'h1);
        rd(5'h10, 32'h0, bbx_pkg::RESP_SLVERR);
        wr(5'h14, 32'h1, bbx_pkg::RESP_SLVERR);
        wr(bbx_pkg::ADDR_COUNT, 32'h5);
        wr(bbx_pkg::ADDR_CTRL, 32'h0);
        @(negedge aclk);
        cmp(instr_ready, 1'h0);
        @(posedge aclk);
        instr <= {bbx_pkg::OP_AND_LIT, 8'h00};
        instr_valid <= 1'h1;
        @(posedge aclk);
        instr_valid <= 1'h0;
        @(negedge aclk);
        cmp(instr_done, 1'h0);
        wr(bbx_pkg::ADDR_CTRL, 32'h1);
        $display("bus test done");
    endtask
    task automatic t_add();
        logic [47:0] tv [3] = '{48'h17_C2_00_7F_D9_00,
            48'h80_80_01_00_00_05, 48'h0F_01_00_3A_10_02};
        logic [6:0] a;
        foreach (tv[i]) begin
            a = tv[i][22:16];
            wr(bbx_pkg::ADDR_ACC, tv[i][47:40]);
            fmem[a] = tv[i][39:32];
            ex(fop(bbx_pkg::OP_ADD_FILE, tv[i][24], a));
            idle();
            cmp(acc, tv[i][24] ? tv[i][47:40] : tv[i][15:8]);
            cmp(fmem[a], tv[i][24] ? tv[i][15:8] : tv[i][39:32]);
            rd(bbx_pkg::ADDR_STATUS, tv[i][7:0]);
        end
        $display("add test done");
    endtask
    task automatic t_and();
        wr(bbx_pkg::ADDR_ACC, 32'h17);
        wr(bbx_pkg::ADDR_STATUS, 32'h1);
        fmem[7'h10] = 8'hC2;
        ex(fop(bbx_pkg::OP_AND_FILE, 1'h1, 7'h10));
        ex(fop(bbx_pkg::OP_AND_FILE, 1'h0, 7'h10));
        ex({bbx_pkg::OP_AND_LIT, 8'h5D});
        idle();
        cmp(fmem[7'h10], 8'h02);
        cmp(acc, 8'h00);
        rd(bbx_pkg::ADDR_STATUS, 32'h5);
        wr(bbx_pkg::ADDR_ACC, 32'hA3);
        ex({bbx_pkg::OP_AND_LIT, 8'h5F});
        idle();
        cmp(acc, 8'h03);
        rd(bbx_pkg::ADDR_STATUS, 32'h1);
        $display("and test done");
    endtask
    task automatic t_bits();
        fmem[7'h3F] = 8'hC7;
        wr(bbx_pkg::ADDR_STATUS, 32'h7);
        for (int b = 0; b < 8; b++)
            ex(bop(bbx_pkg::OP_BIT_SET, 3'(b), 6'h21));
        for (int b = 0; b < 8; b += 2)
            ex(bop(bbx_pkg::OP_BIT_CLR, 3'(b), 6'h21));
        ex(bop(bbx_pkg::OP_BIT_CLR, 3'h7, 6'h3F));
        idle();
        cmp(fmem[7'h21], 8'hAA);
        cmp(fmem[7'h3F], 8'h47);
        rd(bbx_pkg::ADDR_STATUS, 32'h7);
        $display("bit test done");
    endtask
    // Freezing the clock enable ce must hold an offered instruction until it returns.
    task automatic t_hold();
        wr(bbx_pkg::ADDR_ACC, 32'h3C);
        @(posedge aclk);
        ce <= 1'h0;
        instr <= {bbx_pkg::OP_AND_LIT, 8'h0F};
        instr_valid <= 1'h1;
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        cmp(acc, 8'h3C);
        cmp(instr_done, 1'h0);
        @(posedge aclk);
        ce <= 1'h1;
        n_instr++;
        @(posedge aclk);
        instr_valid <= 1'h0;
        @(negedge aclk);
        cmp(acc, 8'h0C);
        cmp(instr_done, 1'h1);
        one(14'h0000);
        cmp(instr_unsupported, 1'h1);
        cmp(acc, 8'h0C);
        $display("hold test done");
    endtask
    task automatic t_skip();
        wr(bbx_pkg::ADDR_ACC, 32'h10);
        wr(bbx_pkg::ADDR_STATUS, 32'h7);
        fmem[7'h05] = 8'h02;
        ex(bop(bbx_pkg::OP_BIT_TEST, 3'h0, 6'h05));
        ex({bbx_pkg::OP_AND_LIT, 8'h00});
        ex({bbx_pkg::OP_AND_LIT, 8'h30});
        idle();
        cmp(acc, 8'h10);
        rd(bbx_pkg::ADDR_STATUS, 32'h3);
        one(bop(bbx_pkg::OP_BIT_TEST, 3'h2, 6'h05));
        cmp(skip_pending, 1'h1);
        rd(bbx_pkg::ADDR_STATUS, 32'hB);
        one({bbx_pkg::OP_AND_LIT, 8'h00});
        cmp(instr_discarded, 1'h1);
        cmp(skip_pending, 1'h0);
        cmp(acc, 8'h10);
        one(bop(bbx_pkg::OP_BIT_TEST, 3'h1, 6'h05));
        cmp(skip_pending, 1'h0);
        one({bbx_pkg::OP_AND_LIT, 8'h00});
        cmp(instr_discarded, 1'h0);
        cmp(acc, 8'h00);
        rd(bbx_pkg::ADDR_COUNT, n_instr);
        $display("skip test done");
    endtask
    initial begin
        aclk = 1'h0;
        aresetn = 1'h0;
        ce = 1'h1;
        instr_valid = 1'h0;
        instr = '0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        foreach (fmem[i]) fmem[i] = 8'h00;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        t_bus();
        t_add();
        t_and();
        t_bits();
        t_hold();
        t_skip();
        end_of_test();
    end
endmodule
